// *** shared/dtrc_pkg.sv ***
// shared constants and types for the two-channel dma transfer request control block
// Behaviour
// - special register area or waited memory adds one bus cycle per access
// - every bus cycle of a transfer lasts one clock period
// - destination writes obey the same width, parity and wait rules as reads
// - any mix of even and odd source and destination addresses is accepted
// - byte unit: one read, one write; word: two reads if source odd, two writes if destination odd, two each on 8-bit bus
// - cycles per unit equal reads times j plus writes times k; j,k are 1, 2 or 3
// - writing one to the activation bit makes the channel active
// - first transfer after activation loads working pointer from forward pointer
// - first transfer after activation copies counter reload into working counter
// - rewriting one while active restarts with both reloads again
// - each channel takes requests only from its software-chosen source
// - sources: peripheral interrupt request, software trigger, external interrupt pin
// - request flag sets on selected request whether active or not
// - request flag clears just before the serving transfer begins
// - software may clear the request flag; writing one does nothing
// - active channel starts at once, so flag reads mostly zero; enable shows activity
// - each unit is a source read cycle followed by a destination write cycle
// - simultaneous requests: channel 0 first, one processor access, then channel 1
package dtrc_pkg;

	localparam int NUM_CH = 2;
	localparam int ADDR_W = 20;
	localparam int CNT_W  = 16;
	localparam int DATA_W = 16;

	// memory area class of an access, sets the coefficient j or k
	localparam logic [1:0] AREA_NOWAIT  = 2'h0;
	localparam logic [1:0] AREA_WAITED  = 2'h1;
	localparam logic [1:0] AREA_SPECIAL = 2'h2;
	localparam logic [1:0] AREA_MUX     = 2'h3;

	// bus cycles per access for each area class
	localparam logic [1:0] COEF_NOWAIT = 2'h1;
	localparam logic [1:0] COEF_WAITED = 2'h2;
	localparam logic [1:0] COEF_MUX    = 2'h3;

	// request source selection codes
	localparam logic [1:0] SRC_SOFTWARE   = 2'h0;
	localparam logic [1:0] SRC_PERIPHERAL = 2'h1;
	localparam logic [1:0] SRC_EXTERNAL   = 2'h2;
	localparam logic [1:0] SRC_NONE       = 2'h3;

	// reset values
	localparam logic                RST_ENABLE = 1'b0;
	localparam logic                RST_FLAG   = 1'b0;
	localparam logic [ADDR_W-1:0]   RST_PTR    = 20'h00000;
	localparam logic [CNT_W-1:0]    RST_COUNT  = 16'h0000;
	localparam logic [DATA_W-1:0]   RST_DATA   = 16'h0000;
	localparam logic [1:0]          RST_WAIT   = 2'h0;

	// pointer steps per transfer unit
	localparam logic [ADDR_W-1:0]   STEP_BYTE  = 20'h00001;
	localparam logic [ADDR_W-1:0]   STEP_WORD  = 20'h00002;
	localparam logic [CNT_W-1:0]    COUNT_ONE  = 16'h0001;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ,
		ST_WRITE,
		ST_CPU_SLOT
	} dtrc_state_t;

endpackage

// *** logic/dtrc_dma_transfer_request_control.sv ***
// two-channel dma engine: request flags, activation reloads and read/write bus sequencing
`timescale 1ns/10ps
`default_nettype none

module dtrc_dma_transfer_request_control (
	input  wire logic                                          clock,
	input  wire logic                                          rst,
	// device mode straps
	input  wire logic                                          expansionMode,
	input  wire logic                                          byteBus,
	// per-channel software control
	input  wire logic [dtrc_pkg::NUM_CH-1:0]                   enableSet,
	input  wire logic [dtrc_pkg::NUM_CH-1:0]                   enableClear,
	input  wire logic [dtrc_pkg::NUM_CH-1:0]                   requestClear,
	input  wire logic [dtrc_pkg::NUM_CH-1:0][1:0]              requestSelect,
	input  wire logic [dtrc_pkg::NUM_CH-1:0]                   transfer_unit_size_select,
	input  wire logic [dtrc_pkg::NUM_CH-1:0]                   sourceForward,
	input  wire logic [dtrc_pkg::NUM_CH-1:0][dtrc_pkg::ADDR_W-1:0] sourcePointer,
	input  wire logic [dtrc_pkg::NUM_CH-1:0][dtrc_pkg::ADDR_W-1:0] destPointer,
	input  wire logic [dtrc_pkg::NUM_CH-1:0][dtrc_pkg::CNT_W-1:0]  countReload,
	input  wire logic [dtrc_pkg::NUM_CH-1:0][1:0]              sourceArea,
	input  wire logic [dtrc_pkg::NUM_CH-1:0][1:0]              destArea,
	// request sources
	input  wire logic [dtrc_pkg::NUM_CH-1:0]                   softwareTrigger,
	input  wire logic [dtrc_pkg::NUM_CH-1:0]                   peripheralIrq,
	input  wire logic [dtrc_pkg::NUM_CH-1:0]                   externalIntPin,
	// per-channel status
	output logic      [dtrc_pkg::NUM_CH-1:0]                   channelActive,
	output logic      [dtrc_pkg::NUM_CH-1:0]                   requestFlag,
	output logic      [dtrc_pkg::NUM_CH-1:0][dtrc_pkg::ADDR_W-1:0] workPointer,
	output logic      [dtrc_pkg::NUM_CH-1:0][dtrc_pkg::CNT_W-1:0]  workCount,
	output logic      [dtrc_pkg::NUM_CH-1:0]                   unitDone,
	// system bus master side
	output logic                                               busOwned,
	output logic                                               busRead,
	output logic                                               busWrite,
	output logic                                               busByteAccess,
	output logic      [dtrc_pkg::ADDR_W-1:0]                   busAddr,
	output logic      [dtrc_pkg::DATA_W-1:0]                   busWrData,
	input  wire logic [dtrc_pkg::DATA_W-1:0]                   busRdData
);

	dtrc_pkg::dtrc_state_t           state_reg;
	logic                            chan_reg;
	logic                            accessIdx_reg;
	logic [1:0]                      waitCnt_reg;
	logic [dtrc_pkg::DATA_W-1:0]     data_reg;
	logic [dtrc_pkg::NUM_CH-1:0]     enable_reg;
	logic [dtrc_pkg::NUM_CH-1:0]     flag_reg;
	logic [dtrc_pkg::NUM_CH-1:0]     pinPrev_reg;
	logic [dtrc_pkg::NUM_CH-1:0]     reloadPending_reg;
	logic [dtrc_pkg::NUM_CH-1:0][dtrc_pkg::ADDR_W-1:0] ptr_reg;
	logic [dtrc_pkg::NUM_CH-1:0][dtrc_pkg::CNT_W-1:0]  count_reg;

	logic [dtrc_pkg::NUM_CH-1:0]     ready;
	logic [dtrc_pkg::NUM_CH-1:0]     startPulse;
	logic [dtrc_pkg::NUM_CH-1:0]     selectedRequest;
	logic                            startGo;
	logic                            pickChan;
	logic                            unitByte;
	logic [dtrc_pkg::ADDR_W-1:0]     srcAddr;
	logic [dtrc_pkg::ADDR_W-1:0]     dstAddr;
	logic [dtrc_pkg::ADDR_W-1:0]     baseAddr;
	logic [1:0]                      coef;
	logic                            twoAccess;
	logic                            lastWait;
	logic                            lastAccess;
	logic                            finishUnit;

	// bus cycles per access from the area class
	function automatic logic [1:0] area_coef(input logic [1:0] area);
		unique case (area)
			dtrc_pkg::AREA_NOWAIT:  area_coef = dtrc_pkg::COEF_NOWAIT;
			dtrc_pkg::AREA_WAITED:  area_coef = dtrc_pkg::COEF_WAITED;
			dtrc_pkg::AREA_SPECIAL: area_coef = dtrc_pkg::COEF_WAITED;
			dtrc_pkg::AREA_MUX:     area_coef = dtrc_pkg::COEF_MUX;
		endcase
	endfunction

	// a word splits into two byte accesses when odd or on the narrow bus
	function automatic logic needs_two(input logic isByte, input logic addrLsb,
			input logic narrow);
		needs_two = !isByte && (addrLsb || narrow);
	endfunction

	// per-channel request, activation, pointer and counter state
	generate
		for (genvar i = 0; i < dtrc_pkg::NUM_CH; i++) begin : g_chan
			// only the selected source can raise this channel's request
			always_comb begin
				unique case (requestSelect[i])
					dtrc_pkg::SRC_SOFTWARE:   selectedRequest[i] = softwareTrigger[i];
					dtrc_pkg::SRC_PERIPHERAL: selectedRequest[i] = peripheralIrq[i];
					dtrc_pkg::SRC_EXTERNAL:   selectedRequest[i] = externalIntPin[i]
						&& !pinPrev_reg[i];
					dtrc_pkg::SRC_NONE:       selectedRequest[i] = 1'b0;
				endcase
			end

			// leading edge detector for the external pin; runs under any selection,
			// so a select change never sees a stale edge left from an earlier pin level
			always_ff @(posedge clock) begin
				if (rst) begin
					pinPrev_reg[i] <= 1'b0;
				end else begin
					pinPrev_reg[i] <= externalIntPin[i];
				end
			end

			// request flag: set wins over both hardware and software clear
			always_ff @(posedge clock) begin
				if (rst) begin
					flag_reg[i] <= dtrc_pkg::RST_FLAG;
				end else if (selectedRequest[i]) begin
					flag_reg[i] <= 1'b1;
				end else if (startPulse[i] || requestClear[i]) begin
					flag_reg[i] <= 1'b0;
				end
			end

			// activation bit; a fresh write also arms both reloads for the next start
			always_ff @(posedge clock) begin
				if (rst) begin
					enable_reg[i]        <= dtrc_pkg::RST_ENABLE;
					reloadPending_reg[i] <= 1'b0;
				end else begin
					if (enableSet[i]) begin
						enable_reg[i]        <= 1'b1;
						reloadPending_reg[i] <= 1'b1;
					end else begin
						if (enableClear[i]) begin
							enable_reg[i] <= 1'b0;
						end else if (finishUnit && chan_reg == 1'(i)
								&& count_reg[i] == dtrc_pkg::COUNT_ONE) begin
							enable_reg[i] <= 1'b0;  // count exhausted
						end
						if (startPulse[i]) begin
							reloadPending_reg[i] <= 1'b0;
						end
					end
				end
			end

			// working pointer and counter: reload at first start, step after each unit
			always_ff @(posedge clock) begin
				if (rst) begin
					ptr_reg[i]   <= dtrc_pkg::RST_PTR;
					count_reg[i] <= dtrc_pkg::RST_COUNT;
				end else if (startPulse[i] && reloadPending_reg[i]) begin
					ptr_reg[i]   <= sourceForward[i] ? sourcePointer[i] : destPointer[i];
					count_reg[i] <= countReload[i];
				end else if (finishUnit && chan_reg == 1'(i)) begin
					ptr_reg[i]   <= ptr_reg[i] + (transfer_unit_size_select[i]
						? dtrc_pkg::STEP_BYTE : dtrc_pkg::STEP_WORD);
					count_reg[i] <= count_reg[i] - dtrc_pkg::COUNT_ONE;
				end
			end

			assign ready[i]      = enable_reg[i] && flag_reg[i];
			assign startPulse[i] = startGo && (pickChan == 1'(i));
			assign unitDone[i]   = finishUnit && (chan_reg == 1'(i));
		end
	endgenerate

	// channel 0 wins when both are pending in the same cycle
	assign pickChan = !ready[0];
	assign startGo  = (state_reg == dtrc_pkg::ST_IDLE) && (|ready);

	// addresses: the forward side uses the working pointer, the other stays fixed
	assign unitByte = transfer_unit_size_select[chan_reg];
	assign srcAddr  = sourceForward[chan_reg] ? ptr_reg[chan_reg] : sourcePointer[chan_reg];
	assign dstAddr  = sourceForward[chan_reg] ? destPointer[chan_reg] : ptr_reg[chan_reg];

	// the write phase is timed by exactly the same rules as the read phase
	always_comb begin
		if (state_reg == dtrc_pkg::ST_WRITE) begin
			baseAddr = dstAddr;
			coef     = area_coef(destArea[chan_reg]);
		end else begin
			baseAddr = srcAddr;
			coef     = area_coef(sourceArea[chan_reg]);
		end
	end

	assign twoAccess  = needs_two(unitByte, baseAddr[0], byteBus && expansionMode);
	assign lastWait   = (waitCnt_reg == coef - 2'h1);
	assign lastAccess = (accessIdx_reg == twoAccess);
	assign finishUnit = (state_reg == dtrc_pkg::ST_WRITE) && lastWait && lastAccess;

	// sequencer: read accesses, write accesses, then one cycle back to the processor
	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= dtrc_pkg::ST_IDLE;
			chan_reg  <= 1'b0;
		end else begin
			unique case (state_reg)
				dtrc_pkg::ST_IDLE: begin
					if (startGo) begin
						state_reg <= dtrc_pkg::ST_READ;
						chan_reg  <= pickChan;
					end
				end
				dtrc_pkg::ST_READ: begin
					if (lastWait && lastAccess) begin
						state_reg <= dtrc_pkg::ST_WRITE;
					end
				end
				dtrc_pkg::ST_WRITE: begin
					if (lastWait && lastAccess) begin
						state_reg <= dtrc_pkg::ST_CPU_SLOT;
					end
				end
				dtrc_pkg::ST_CPU_SLOT: begin
					state_reg <= dtrc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// access and wait counters; each bus cycle is one clock
	always_ff @(posedge clock) begin
		if (rst) begin
			waitCnt_reg   <= dtrc_pkg::RST_WAIT;
			accessIdx_reg <= 1'b0;
		end else if (state_reg == dtrc_pkg::ST_READ || state_reg == dtrc_pkg::ST_WRITE) begin
			if (lastWait) begin
				waitCnt_reg   <= dtrc_pkg::RST_WAIT;
				accessIdx_reg <= lastAccess ? 1'b0 : 1'b1;
			end else begin
				waitCnt_reg <= waitCnt_reg + 2'h1;
			end
		end else begin
			waitCnt_reg   <= dtrc_pkg::RST_WAIT;
			accessIdx_reg <= 1'b0;
		end
	end

	// read data capture; split accesses carry one byte each on the low lane
	always_ff @(posedge clock) begin
		if (rst) begin
			data_reg <= dtrc_pkg::RST_DATA;
		end else if (state_reg == dtrc_pkg::ST_READ && lastWait) begin
			if (!twoAccess) begin
				data_reg <= unitByte ? {8'h00, busRdData[7:0]} : busRdData;
			end else if (!accessIdx_reg) begin
				data_reg[7:0] <= busRdData[7:0];
			end else begin
				data_reg[15:8] <= busRdData[7:0];
			end
		end
	end

	// bus drive: the split second access goes to the following byte address
	assign busOwned      = (state_reg == dtrc_pkg::ST_READ) || (state_reg == dtrc_pkg::ST_WRITE);
	assign busRead       = (state_reg == dtrc_pkg::ST_READ);
	assign busWrite      = (state_reg == dtrc_pkg::ST_WRITE);
	assign busByteAccess = busOwned && (unitByte || twoAccess);
	assign busAddr       = busOwned ? baseAddr + {19'h00000, accessIdx_reg} : dtrc_pkg::RST_PTR;
	assign busWrData     = !busWrite ? dtrc_pkg::RST_DATA
		: (twoAccess && accessIdx_reg) ? {8'h00, data_reg[15:8]} : data_reg;

	// status shown to software: activity lives in the enable bit, not the flag
	assign channelActive = enable_reg;
	assign requestFlag   = flag_reg;
	assign workPointer   = ptr_reg;
	assign workCount     = count_reg;

endmodule

`default_nettype wire

// *** verification/dtrc_properties.sv ***
// checker for request flags, activation and bus sequencing of the dma block
`timescale 1ns/10ps
`default_nettype none
module dtrc_properties (
	input wire logic             clock,
	input wire logic             rst,
	input wire logic [1:0]       enableSet,
	input wire logic [1:0]       requestClear,
	input wire logic [1:0][1:0]  requestSelect,
	input wire logic [1:0]       softwareTrigger,
	input wire logic [1:0]       peripheralIrq,
	input wire logic [1:0]       externalIntPin,
	input wire logic [1:0]       channelActive,
	input wire logic [1:0]       requestFlag,
	input wire logic [1:0][15:0] workCount,
	input wire logic [1:0]       unitDone,
	input wire logic             busOwned,
	input wire logic             busRead,
	input wire logic             busWrite
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// both channels armed and pending, bus taken on the next edge
	sequence bothPend;
		requestFlag == 2'h3 && channelActive == 2'h3 && !busOwned ##1 busRead;
	endsequence
	// processor slot plus idle cycle handed back after every unit
	sequence procGap;
		!busOwned ##1 !busOwned;
	endsequence
	AST_ACT: assert property (enableSet[0] |=> channelActive[0])
		else $error("channel 0 not active after set");
	AST_FLAG_SET: assert property (requestSelect[0] == dtrc_pkg::SRC_PERIPHERAL
		&& $stable(requestSelect[0]) && peripheralIrq[0] |=> requestFlag[0])
		else $error("selected request did not set flag");
	AST_CLR: assert property (requestClear[0] && !softwareTrigger[0] && !peripheralIrq[0]
		&& !externalIntPin[0] && $stable(requestSelect[0]) |=> !requestFlag[0])
		else $error("flag survived a clear");
	AST_UNSEL: assert property (requestSelect[1] == dtrc_pkg::SRC_NONE
		&& $stable(requestSelect[1]) && !requestFlag[1] |=> !requestFlag[1])
		else $error("flag set with no source selected");
	AST_READ_FIRST: assert property ($rose(busOwned) |-> busRead && !busWrite)
		else $error("unit did not open with a read");
	AST_WRITE_AFTER: assert property ($fell(busRead) |-> busWrite)
		else $error("read not followed by write");
	AST_SLOT: assert property ($fell(busWrite) |-> procGap)
		else $error("bus not returned after unit");
	AST_CNT: assert property (unitDone[0] && workCount[0] != 16'h0001
		|=> workCount[0] == $past(workCount[0]) - 16'h0001)
		else $error("count did not step");
	AST_PRIO: assert property (bothPend |-> !unitDone[1] throughout (##[0:12] unitDone[0]))
		else $error("channel 1 served before channel 0");
endmodule
bind dtrc_dma_transfer_request_control dtrc_properties chk (.clock, .rst, .enableSet,
	.requestClear, .requestSelect, .softwareTrigger, .peripheralIrq, .externalIntPin,
	.channelActive, .requestFlag, .workCount, .unitDone, .busOwned, .busRead, .busWrite);
`default_nettype wire

// *** verification/dtrc_memory_model.sv ***
// memory and special register area model answering the engine's source reads
`timescale 1ns/10ps
`default_nettype none
module dtrc_memory_model (
	input wire logic        clock,
	input wire logic        busRead,
	input wire logic [19:0] busAddr,
	output logic     [15:0] busRdData
);
	logic [15:0] lastReg = 16'h0000;
	// remember the last answer so an idle bus can show its inverse
	always_ff @(posedge clock) begin
		if (busRead) begin
			lastReg <= {busAddr[7:0], ~busAddr[7:0]};
		end
	end
	// stale data differs from the last real answer, so a late sample is visible
	assign busRdData = busRead ? {busAddr[7:0], ~busAddr[7:0]} : ~lastReg;
endmodule
`default_nettype wire

// *** verification/dtrc_dma_transfer_request_control_bench.sv ***
// self-checking bench for the two-channel dma transfer request control block
`timescale 1ns/10ps
`default_nettype none
module dtrc_dma_transfer_request_control_bench;
	logic clock, rst, expansionMode, byteBus, busOwned, busRead, busWrite, busByteAccess;
	logic [1:0] enableSet, enableClear, requestClear, transfer_unit_size_select;
	logic [1:0] sourceForward, softwareTrigger, peripheralIrq, externalIntPin;
	logic [1:0] channelActive, requestFlag, unitDone;
	logic [1:0][1:0] requestSelect, sourceArea, destArea;
	logic [1:0][19:0] sourcePointer, destPointer, workPointer;
	logic [1:0][15:0] countReload, workCount;
	logic [19:0] busAddr;
	logic [15:0] busWrData, busRdData;
	int bad_count = 0;
	int total_checks = 0;
	int cycles = 0;
	dtrc_dma_transfer_request_control DUT (.clock, .rst, .expansionMode, .byteBus,
		.enableSet, .enableClear, .requestClear, .requestSelect, .transfer_unit_size_select,
		.sourceForward, .sourcePointer, .destPointer, .countReload, .sourceArea, .destArea,
		.softwareTrigger, .peripheralIrq, .externalIntPin, .channelActive, .requestFlag,
		.workPointer, .workCount, .unitDone, .busOwned, .busRead, .busWrite,
		.busByteAccess, .busAddr, .busWrData, .busRdData);
	dtrc_memory_model mem (.clock, .busRead, .busAddr, .busRdData);
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// a hang is cut short well beyond the few hundred cycles the tests need
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			bad_count++;
			$display("unexpected at %0t: run too long", $time);
			give_verdict;
		end
	end
	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
		end
	endtask
	function automatic int coef(input logic [1:0] a);
		return (a == dtrc_pkg::AREA_MUX) ? 3 : (a == dtrc_pkg::AREA_NOWAIT) ? 1 : 2;
	endfunction
	// one request pulse per source bit {pin, peripheral, software} on both channels
	task automatic fire(input logic [2:0] m);
		@(posedge clock);
		{externalIntPin, peripheralIrq, softwareTrigger} <= {{2{m[2]}}, {2{m[1]}}, {2{m[0]}}};
		@(posedge clock);
		{externalIntPin, peripheralIrq, softwareTrigger} <= '0;
		@(negedge clock);
	endtask
	task automatic pulse_set(input logic [1:0] ch);
		@(posedge clock);
		enableSet <= ch;
		@(posedge clock);
		enableSet <= 2'h0;
	endtask
	task automatic clear_flags;
		@(posedge clock);
		requestClear <= 2'h3;
		@(posedge clock);
		requestClear <= 2'h0;
	endtask
	// each source code except SRC_NONE on an idle channel: others ignored, own one sets the flag
	task automatic t_flags;
		for (int s = 0; s < 3; s++) begin
			@(posedge clock);
			requestSelect[0] <= 2'(s);
			clear_flags;
			fire(3'h7 ^ (3'h1 << s));
			check(requestFlag, 2'h0, "unselected source");
			fire(3'h1 << s);
			check(requestFlag, 2'h1, "selected source");
		end
		clear_flags;
		@(negedge clock);
		check(requestFlag, 2'h0, "software clear");
		$display("flag test done");
	endtask
	// one unit on channel 0, bus cycles counted over a fixed window
	task automatic t_xfer(input logic u, input logic [19:0] s, d, input logic [1:0] sa, da,
		input logic bb);
		int rd, wr, nr, nw;
		rd = 0;
		wr = 0;
		nr = (!u && (s[0] || bb)) ? 2 : 1;
		nw = (!u && (d[0] || bb)) ? 2 : 1;
		@(posedge clock);
		expansionMode <= bb;
		byteBus <= bb;
		transfer_unit_size_select[0] <= u;
		sourcePointer[0] <= s;
		destPointer[0] <= d;
		sourceArea[0] <= sa;
		destArea[0] <= da;
		pulse_set(2'h1);
		fire(3'h1);
		check(requestFlag[0], 1'b1, "flag before start");
		for (int c = 0; c < 24; c++) begin
			@(negedge clock);
			// first cycle of each phase: address, width and the first byte moved
			if (busRead && rd == 0) begin
				check(busAddr, s, "source address");
				check(busByteAccess, u || nr == 2, "read access width");
			end
			if (busWrite && wr == 0) begin
				check(busAddr, d, "destination address");
				check(busWrData[7:0], {~s[7:0]}, "first byte written");
				check(busByteAccess, u || nw == 2, "write access width");
			end
			rd += busRead;
			wr += busWrite;
		end
		check(rd, nr * coef(sa), "read cycles");
		check(wr, nw * coef(da), "write cycles");
		check(workPointer[0], s + (u ? 20'h00001 : 20'h00002), "forward pointer");
		check(workCount[0], 16'h0004, "count reloaded");
		check({channelActive[0], requestFlag[0]}, 2'h2, "flag cleared, still active");
		$display("transfer test done");
	endtask
	task automatic t_restart;
		fire(3'h1);
		repeat (20) @(negedge clock);
		check(workCount[0], 16'h0003, "count carries on");
		@(posedge clock);
		sourceForward[0] <= 1'b0;
		pulse_set(2'h1);
		fire(3'h1);
		repeat (20) @(negedge clock);
		check(workCount[0], 16'h0004, "count reloaded again");
		check(workPointer[0], destPointer[0] + (transfer_unit_size_select[0] ? 20'h00001
			: 20'h00002), "pointer from destination");
		$display("restart test done");
	endtask
	// simultaneous pin edges: channel 0 first, then slot, idle, one-cycle read and write
	task automatic t_prio;
		int d0, d1;
		d0 = -1;
		d1 = -1;
		@(posedge clock);
		requestSelect <= {dtrc_pkg::SRC_EXTERNAL, dtrc_pkg::SRC_EXTERNAL};
		transfer_unit_size_select[1] <= 1'b1;
		clear_flags;
		pulse_set(2'h3);
		fire(3'h4);
		for (int c = 0; c < 30; c++) begin
			@(negedge clock);
			if (unitDone[0] && d0 < 0) d0 = c;
			if (unitDone[1] && d1 < 0) d1 = c;
		end
		check(d0 >= 0 && d1 > d0, 1'b1, "channel 0 first");
		check(d1 - d0, 4, "gap between channels");
		$display("priority test done");
	endtask
	initial begin
		rst = 1'b1;
		expansionMode = 1'b0;
		byteBus = 1'b0;
		{enableSet, enableClear, requestClear, softwareTrigger, peripheralIrq} = '0;
		externalIntPin = '0;
		transfer_unit_size_select = '0;
		sourceForward = 2'h3;
		requestSelect = {dtrc_pkg::SRC_NONE, dtrc_pkg::SRC_SOFTWARE};
		{sourceArea, destArea, sourcePointer, destPointer} = '0;
		countReload = {16'h0005, 16'h0005};
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		check({channelActive, requestFlag}, 4'h0, "reset state");
		t_flags;
		@(posedge clock);
		requestSelect[0] <= dtrc_pkg::SRC_SOFTWARE;
		clear_flags;
		t_xfer(1'b1, 20'h00100, 20'h00201, 2'h0, 2'h0, 1'b0);
		t_xfer(1'b0, 20'h00301, 20'h00400, 2'h1, 2'h0, 1'b0);
		t_xfer(1'b0, 20'h00500, 20'h00600, 2'h2, 2'h3, 1'b0);
		t_xfer(1'b0, 20'h00700, 20'h00800, 2'h0, 2'h1, 1'b1);
		t_xfer(1'b1, 20'h00901, 20'h00A01, 2'h3, 2'h2, 1'b1);
		t_restart;
		t_prio;
		give_verdict;
	end
endmodule
`default_nettype wire
